// >>> mrsm_pkg.sv
// constants and types for the receive status and phy management block
//
// Contract
// - phy flags bad code group on receive error; sampled on receive clock in mii (in dce mode the code samples it on the reference clock).
// - receive error is ignored whenever carrier-sense/data-valid is low.
// - in rmii, receive error is sampled on the shared reference clock.
// - collision input acts only in half duplex, ignored in full duplex.
// - management clock divided from system clock, at most 1.67 MHz, times all exchanges.
// - management port reads and writes 32 registers in each of 32 phy addresses (in dce mode the code refuses all requests).
// - device can start phy auto-negotiation through management writes (in dce mode the code ignores the start request).
// - in dce mode receive clock is driven out: 25 MHz or 2.5 MHz.
package mrsm_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_SYS_KHZ  = 250000;
  localparam int MDC_MAX_KHZ  = 1670;
  localparam int MDC_HALF_INT = (CLK_SYS_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam logic [7:0] MDC_HALF = 8'(MDC_HALF_INT);
  // reference edges per half period of the driven receive clock
  localparam logic [3:0] DCE_HALF_100 = 4'h1;
  localparam logic [3:0] DCE_HALF_10  = 4'hA;

  // ==========================================================================
  // management frame
  localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0]  MDIO_START    = 2'h1;
  localparam logic [1:0]  MDIO_OP_WR    = 2'h1;
  localparam logic [1:0]  MDIO_OP_RD    = 2'h2;
  localparam logic [1:0]  MDIO_TA_WR    = 2'h2;
  localparam logic [1:0]  MDIO_TA_RD    = 2'h3;
  localparam logic [15:0] MDIO_RD_FILL  = 16'hFFFF;
  localparam logic [5:0]  MDIO_LAST_BIT = 6'h3F;
  localparam logic [5:0]  MDIO_TURN_BIT = 6'h2E;
  localparam logic [5:0]  MDIO_DATA_BIT = 6'h30;
  // auto-negotiation start: control register, enable and restart bits
  localparam logic [4:0]  AN_REG_ADDR   = 5'h00;
  localparam logic [15:0] AN_CTRL_DATA  = 16'h1200;

  // ==========================================================================
  // types
  typedef struct packed {
    logic        write;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mrsm_cmd_t;

  typedef struct packed {
    logic rx_clk;
    logic ref_clk;
    logic crs_dv;
    logic rx_err;
    logic col_det;
  } mrsm_rx_pins_t;

  typedef enum logic {
    MRSM_IDLE,
    MRSM_SHIFT
  } mrsm_mdio_st_t;

  typedef struct packed {
    mrsm_mdio_st_t st;
    logic [7:0]    cnt;
    logic          mdc;
    logic [5:0]    bit_idx;
    logic [63:0]   shreg;
    logic          is_read;
    logic          oe;
    logic [15:0]   rdata;
    logic          done;
    logic          sync1;
    logic          sync2;
  } mrsm_mdio_state_t;

  typedef struct packed {
    mrsm_rx_pins_t sync1;
    mrsm_rx_pins_t sync2;
    logic          rx_clk_prev;
    logic          ref_clk_prev;
    logic          err_event;
    logic          frame_err;
    logic          collision;
    logic [3:0]    dce_cnt;
    logic          rx_clk_out;
    logic          an_pend;
    logic          rsp_valid;
    logic          rsp_write;
    logic          cur_write;
  } mrsm_top_state_t;

endpackage

// >>> mrsm_mdio.sv
// management frame engine: clock divider and serial shifter
`timescale 1ns/1ps
module mrsm_mdio (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire mrsm_pkg::mrsm_cmd_t cmd,
  output logic                   busy,
  output logic                   done,
  output logic [15:0]            rdata,
  output logic                   mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe
);

  mrsm_pkg::mrsm_mdio_state_t s;
  mrsm_pkg::mrsm_mdio_state_t next_s;

  // ==========================================================================
  // next state
  always_comb begin
    next_s       = s;
    next_s.done  = 1'b0;
    next_s.sync1 = mdio_i;
    next_s.sync2 = s.sync1;
    unique case (s.st)
      mrsm_pkg::MRSM_IDLE: begin
        next_s.mdc = 1'b0;
        next_s.oe  = 1'b0;
        next_s.cnt = 8'h00;
        if (start) begin
          next_s.shreg   = {mrsm_pkg::MDIO_PREAMBLE, mrsm_pkg::MDIO_START,
                            cmd.write ? mrsm_pkg::MDIO_OP_WR : mrsm_pkg::MDIO_OP_RD,
                            cmd.phy_addr, cmd.reg_addr,
                            cmd.write ? mrsm_pkg::MDIO_TA_WR : mrsm_pkg::MDIO_TA_RD,
                            cmd.write ? cmd.wdata : mrsm_pkg::MDIO_RD_FILL};
          next_s.is_read = ~cmd.write;
          next_s.bit_idx = 6'h00;
          next_s.oe      = 1'b1;
          next_s.st      = mrsm_pkg::MRSM_SHIFT;
        end
      end
      mrsm_pkg::MRSM_SHIFT: begin
        if (s.cnt == mrsm_pkg::MDC_HALF - 8'h01) begin
          next_s.cnt = 8'h00;
          next_s.mdc = ~s.mdc;
          if (!s.mdc) begin
            if (s.is_read && s.bit_idx >= mrsm_pkg::MDIO_DATA_BIT) begin
              next_s.rdata = {s.rdata[14:0], s.sync2};
            end
          end else if (s.bit_idx == mrsm_pkg::MDIO_LAST_BIT) begin
            next_s.st   = mrsm_pkg::MRSM_IDLE;
            next_s.oe   = 1'b0;
            next_s.done = 1'b1;
          end else begin
            next_s.bit_idx = s.bit_idx + 6'h01;
            next_s.shreg   = {s.shreg[62:0], 1'b1};
            next_s.oe      = ~(s.is_read && (s.bit_idx + 6'h01) >= mrsm_pkg::MDIO_TURN_BIT);
          end
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s    <= '0;
      s.st <= mrsm_pkg::MRSM_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign busy    = (s.st == mrsm_pkg::MRSM_SHIFT);
  assign done    = s.done;
  assign rdata   = s.rdata;
  assign mdc     = s.mdc;
  assign mdio_o  = s.shreg[63];
  assign mdio_oe = s.oe;

endmodule

// >>> mrsm_top.sv
// receive status qualification, dce receive clock and phy management port
`timescale 1ns/1ps
module mrsm_top (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              rmii_mode,
  input  wire logic              dce_mode,
  input  wire logic              full_duplex,
  input  wire logic              speed_100,
  input  wire logic              rx_clk_i,
  input  wire logic              ref_clk,
  input  wire logic              crs_dv,
  input  wire logic              rx_err,
  input  wire logic              col_det,
  output logic                   rx_clk_o,
  output logic                   rx_clk_oe,
  output logic                   rx_error_event,
  output logic                   rx_frame_error,
  output logic                   collision,
  input  wire logic              cmd_valid,
  input  wire mrsm_pkg::mrsm_cmd_t cmd,
  output logic                   cmd_ready,
  input  wire logic              an_start,
  input  wire logic [4:0]        an_phy_addr,
  output logic                   an_pending,
  output logic                   rsp_valid,
  output logic                   rsp_write,
  output logic [15:0]            rsp_rdata,
  output logic                   mgmt_busy,
  output logic                   mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe
);

  mrsm_pkg::mrsm_top_state_t s;
  mrsm_pkg::mrsm_top_state_t next_s;
  mrsm_pkg::mrsm_rx_pins_t   pins;
  mrsm_pkg::mrsm_cmd_t       eng_cmd;
  logic                      eng_start;
  logic                      eng_busy;
  logic                      eng_done;
  logic [15:0]               eng_rdata;
  logic                      rx_clk_rise;
  logic                      ref_clk_rise;
  logic                      rx_sample;
  logic                      err_hit;
  logic                      mgmt_enable;

  // ==========================================================================
  // helpers
  // rising edge seen on a synchronised pin
  function automatic logic mrsm_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [3:0] mrsm_dce_half(input logic fast);
    return fast ? mrsm_pkg::DCE_HALF_100 : mrsm_pkg::DCE_HALF_10;
  endfunction

  function automatic mrsm_pkg::mrsm_cmd_t mrsm_an_cmd(input logic [4:0] phy);
    mrsm_pkg::mrsm_cmd_t c;
    c          = '0;
    c.write    = 1'b1;
    c.phy_addr = phy;
    c.reg_addr = mrsm_pkg::AN_REG_ADDR;
    c.wdata    = mrsm_pkg::AN_CTRL_DATA;
    return c;
  endfunction

  // ==========================================================================
  // pin gathering
  always_comb begin
    pins.rx_clk  = rx_clk_i;
    pins.ref_clk = ref_clk;
    pins.crs_dv  = crs_dv;
    pins.rx_err  = rx_err;
    pins.col_det = col_det;
  end

  // ==========================================================================
  // receive clock edges, taken from the second synchroniser stage only
  assign rx_clk_rise  = mrsm_rise(s.sync2.rx_clk, s.rx_clk_prev);
  assign ref_clk_rise = mrsm_rise(s.sync2.ref_clk, s.ref_clk_prev);

  assign rx_sample = (rmii_mode || dce_mode) ? ref_clk_rise : rx_clk_rise;

  assign err_hit = rx_sample & s.sync2.crs_dv & s.sync2.rx_err;

  assign mgmt_enable = ~dce_mode;

  // ==========================================================================
  // management request selection
  always_comb begin
    eng_start = 1'b0;
    eng_cmd   = cmd;
    if (mgmt_enable && !eng_busy) begin
      if (s.an_pend) begin
        eng_start = 1'b1;
        eng_cmd   = mrsm_an_cmd(an_phy_addr);
      end else if (cmd_valid) begin
        eng_start = 1'b1;
      end
    end
  end

  // ==========================================================================
  // request acceptance
  // refused in dce
  assign cmd_ready = mgmt_enable & ~eng_busy & ~s.an_pend;

  // ==========================================================================
  // next state
  always_comb begin
    next_s              = s;
    next_s.sync1        = pins;
    next_s.sync2        = s.sync1;
    next_s.rx_clk_prev  = s.sync2.rx_clk;
    next_s.ref_clk_prev = s.sync2.ref_clk;
    next_s.err_event    = err_hit;
    next_s.rsp_valid    = eng_done;
    next_s.rsp_write    = s.cur_write;

    // ==========================================================================
    // receive status
    // frame error holds until carrier/valid drops; a new error wins
    if (err_hit) begin
      next_s.frame_err = 1'b1;
    end else if (!s.sync2.crs_dv) begin
      next_s.frame_err = 1'b0;
    end

    // ==========================================================================
    // collision
    // collision half duplex only
    next_s.collision = s.sync2.col_det & ~full_duplex;

    // ==========================================================================
    // dce receive clock
    // dce receive clock
    if (!dce_mode) begin
      next_s.dce_cnt    = 4'h0;
      next_s.rx_clk_out = 1'b0;
    end else if (ref_clk_rise) begin
      if (s.dce_cnt + 4'h1 >= mrsm_dce_half(speed_100)) begin
        next_s.dce_cnt    = 4'h0;
        next_s.rx_clk_out = ~s.rx_clk_out;
      end else begin
        next_s.dce_cnt = s.dce_cnt + 4'h1;
      end
    end

    // ==========================================================================
    // auto-negotiation queue
    // auto-negotiation request waits for the engine; a new request wins
    if (an_start && mgmt_enable) begin
      next_s.an_pend = 1'b1;
    end else if (eng_start && s.an_pend) begin
      next_s.an_pend = 1'b0;
    end else if (!mgmt_enable) begin
      next_s.an_pend = 1'b0;
    end

    if (eng_start) begin
      next_s.cur_write = eng_cmd.write;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // management engine
  // clock and frame engine
  mrsm_mdio u_mdio (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (eng_start),
    .cmd     (eng_cmd),
    .busy    (eng_busy),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .mdc     (mdc),
    .mdio_i  (mdio_i),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe)
  );

  // ==========================================================================
  // outputs
  // driven receive clock
  assign rx_clk_o       = s.rx_clk_out;
  assign rx_clk_oe      = dce_mode;

  assign rx_error_event = s.err_event;
  assign rx_frame_error = s.frame_err;

  assign collision      = s.collision;

  assign an_pending     = s.an_pend;
  assign rsp_valid      = s.rsp_valid;
  assign rsp_write      = s.rsp_write;
  assign rsp_rdata      = eng_rdata;
  assign mgmt_busy      = eng_busy;

endmodule

// >>> mrsm_top_checker.sv
// port assertions for the receive status and management block
`timescale 1ns/1ps
module mrsm_top_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic dce_mode,
  input wire logic full_duplex,
  input wire logic crs_dv,
  input wire logic rx_error_event,
  input wire logic rx_frame_error,
  input wire logic collision,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic an_pending,
  input wire logic rsp_valid,
  input wire logic mgmt_busy,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  // ====
  // phase length of the management clock
  logic [7:0] hcnt;
  logic       mdc_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hcnt  <= 8'h00;
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
      hcnt  <= (mdc != mdc_q) ? 8'h00 : hcnt + 8'h01;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_take; cmd_valid && cmd_ready && !an_pending; endsequence
  sequence s_preamble; ##[1:2] (mdio_oe && mdio_o); endsequence
  property p_err_gate; (!crs_dv)[*6] |-> !rx_error_event && !rx_frame_error; endproperty
  a_err_gate: assert property (p_err_gate) else $error("error without carrier");
  property p_col_fd; full_duplex[*2] |-> !collision; endproperty
  a_col_fd: assert property (p_col_fd) else $error("collision in full duplex");
  property p_mdc_half; $fell(mdc) |-> hcnt == 8'h4A; endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("mdc high phase length");
  property p_one_busy; mgmt_busy |-> !cmd_ready; endproperty
  a_one_busy: assert property (p_one_busy) else $error("ready while busy");
  property p_take; s_take |=> mgmt_busy && !cmd_ready; endproperty
  a_take: assert property (p_take) else $error("take did not start engine");
  property p_an_first; an_pending |-> !cmd_ready; endproperty
  a_an_first: assert property (p_an_first) else $error("ready while pending");
  property p_dce_port; dce_mode |-> !cmd_ready; endproperty
  a_dce_port: assert property (p_dce_port) else $error("ready in dce");
  property p_frame; s_take |-> s_preamble; endproperty
  a_frame: assert property (p_frame) else $error("no preamble after take");
  property p_end; rsp_valid |-> !$past(mdio_oe) && !mdc ##1 !rsp_valid; endproperty
  a_end: assert property (p_end) else $error("bad frame end");
endmodule

bind mrsm_top mrsm_top_checker mrsm_top_checker_inst (
  .clk_sys, .reset_n, .dce_mode, .full_duplex, .crs_dv, .rx_error_event, .rx_frame_error,
  .collision, .cmd_valid, .cmd_ready, .an_pending, .rsp_valid, .mgmt_busy, .mdc, .mdio_o,
  .mdio_oe
);

// >>> mrsm_phy_model.sv
// phy model: free clocks and management register responder
`timescale 1ns/1ps
module mrsm_phy_model (
  input  wire logic dce_mode,
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      rx_clk_i,
  output logic      ref_clk,
  output logic      mdio_line
);
  logic [63:0] sr = '0;
  logic [15:0] regs [32][32];
  logic [4:0]  ph;
  logic [4:0]  rg;
  logic        rd;
  logic        drv = 1'b0;
  logic        dat;
  int          b = 64;
  initial begin
    ref_clk = 1'b0;
    #3;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rx_clk_i = 1'b0;
    #1;
    forever #20 rx_clk_i = ~rx_clk_i;
  end
  always @(posedge mdc) begin
    sr = {sr[62:0], mdio_line};
    b = (sr[33:0] == {32'hFFFF_FFFF, 2'h1}) ? 33 : b + (b < 64);
    if (b == 45) begin
      rd = (sr[11:10] == 2'h2);
      ph = sr[9:5];
      rg = sr[4:0];
    end
    if (b == 63 && !rd) regs[ph][rg] = sr[15:0];
    drv = rd && !dce_mode && b >= 46 && b <= 62;
    dat = (b == 46) ? 1'b0 : regs[ph][rg][62-b];
  end
  // pull-up on the shared line
  assign mdio_line = mdio_oe ? mdio_o : (drv ? dat : 1'b1);
endmodule

// >>> mrsm_tb_top.sv
// self-checking bench for the receive status and management block
`timescale 1ns/1ps
module mrsm_tb_top;
  localparam int REF_KHZ = 50000;
  logic                clk_sys, reset_n, rmii_mode, dce_mode, full_duplex, speed_100;
  logic                rx_clk_i, ref_clk, crs_dv, rx_err, col_det, rx_clk_o, rx_clk_oe;
  logic                rx_error_event, rx_frame_error, collision, cmd_valid, cmd_ready;
  logic                an_start, an_pending, rsp_valid, rsp_write, mgmt_busy;
  logic                mdc, mdio_i, mdio_o, mdio_oe;
  logic [4:0]          an_phy_addr, pa, ra;
  logic [15:0]         rsp_rdata;
  logic [31:0]         seed;
  mrsm_pkg::mrsm_cmd_t cmd;
  int                  failures, samples_checked, cycles, exp_evt, got_evt, ref_rises, mark;
  int                  exp_regs[int];
  wire                 edge_src = rmii_mode ? ref_clk : rx_clk_i;

  mrsm_top mrsm_top_inst (
    .clk_sys, .reset_n, .rmii_mode, .dce_mode, .full_duplex, .speed_100, .rx_clk_i,
    .ref_clk, .crs_dv, .rx_err, .col_det, .rx_clk_o, .rx_clk_oe, .rx_error_event,
    .rx_frame_error, .collision, .cmd_valid, .cmd, .cmd_ready, .an_start, .an_phy_addr,
    .an_pending, .rsp_valid, .rsp_write, .rsp_rdata, .mgmt_busy, .mdc, .mdio_i, .mdio_o,
    .mdio_oe
  );
  mrsm_phy_model mrsm_phy_model_inst (
    .dce_mode, .mdc, .mdio_o, .mdio_oe, .rx_clk_i, .ref_clk, .mdio_line(mdio_i)
  );

  // ====
  // clock, watchdog, bench counts
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (rx_error_event === 1'b1) got_evt++;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end
  always @(posedge edge_src) if (crs_dv && rx_err) exp_evt++;
  always @(posedge ref_clk) ref_rises++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      failures++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_rsp(input logic w);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rsp_valid !== 1'b1 && n < 12000);
    chk_val("rsp", {14'h0000, 1'b1, w}, {14'h0000, rsp_valid, rsp_write});
  endtask
  task automatic mgmt(input logic w, input logic [4:0] p, input logic [4:0] r,
                      input logic [15:0] d);
    int n;
    n = 0;
    cmd = '{w, p, r, d};
    cmd_valid = 1'b1;
    while ((cmd_ready !== 1'b1 || an_pending !== 1'b0) && n < 99) begin
      tick(1);
      n++;
    end
    tick(1);
    cmd_valid = 1'b0;
    tick(1);
    chk_val("cmd_ready", 16'h0000, {15'h0000, cmd_ready});
    wait_rsp(w);
    if (w) exp_regs[{p, r}] = d;
    else chk_val("rdata", 16'(exp_regs[{p, r}]), rsp_rdata);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ====
  // main sequence
  initial begin
    seed = 32'h97ad_72b3;
    {reset_n, rmii_mode, dce_mode, full_duplex, speed_100} = '0;
    {crs_dv, rx_err, col_det, cmd_valid, an_start} = '0;
    cmd = '0;
    an_phy_addr = 5'h00;
    tick(2);
    chk_val("mdio_oe", 16'h0000, {15'h0000, mdio_oe});
    reset_n = 1'b1;
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      rmii_mode = m[0];
      for (int k = 0; k < 4; k++) begin
        {exp_evt, got_evt} = '0;
        crs_dv = k[0];
        tick(12);
        rx_err = 1'b1;
        tick(10 + rnd() % 30);
        rx_err = 1'b0;
        tick(12);
        chk_val("frame_error", {15'h0000, k[0]}, {15'h0000, rx_frame_error});
        crs_dv = 1'b0;
        tick(12);
        chk_cnt("error events", exp_evt, got_evt);
        chk_val("frame_error", 16'h0000, {15'h0000, rx_frame_error});
      end
    end
    $display("test receive error done");
    for (int f = 0; f < 2; f++) begin
      full_duplex = f[0];
      col_det = 1'b1;
      tick(8);
      chk_val("collision", {15'h0000, ~f[0]}, {15'h0000, collision});
      col_det = 1'b0;
      tick(8);
    end
    $display("test collision done");
    // error and collision pins stay low
    dce_mode = 1'b1;
    for (int s = 0; s < 2; s++) begin
      speed_100 = s[0];
      cmd_valid = 1'b1;
      tick(120);
      cmd_valid = 1'b0;
      chk_val("dce outs", 16'h0002, {14'h0000, rx_clk_oe, mgmt_busy});
      @(posedge rx_clk_o);
      mark = ref_rises;
      @(posedge rx_clk_o);
      chk_cnt("ref per rx clock", REF_KHZ / (s ? 25000 : 2500), ref_rises - mark);
      tick(1);
    end
    dce_mode = 1'b0;
    tick(4);
    $display("test dce done");
    pa = 5'h1F;
    ra = 5'(rnd());
    mgmt(1'b1, pa, ra, 16'(rnd()));
    mgmt(1'b0, pa, ra, 16'h0000);
    an_phy_addr = 5'(rnd());
    an_start = 1'b1;
    tick(1);
    an_start = 1'b0;
    chk_val("an_pending", 16'h0001, {15'h0000, an_pending});
    wait_rsp(1'b1);
    exp_regs[{an_phy_addr, mrsm_pkg::AN_REG_ADDR}] = mrsm_pkg::AN_CTRL_DATA;
    mgmt(1'b0, an_phy_addr, mrsm_pkg::AN_REG_ADDR, 16'h0000);
    $display("test management done");
    finish_test();
  end
endmodule
